// ==== hw/irq_level_pkg.sv ====
// Constants shared by the interrupt level register block.
// Assumes an APB master on the system clock and request lines from same-clock logic.
package irq_level_pkg;

  localparam int NUM_GROUPS  = 13;
  localparam int FIELDS      = 4;
  localparam int NUM_SOURCES = NUM_GROUPS * FIELDS;
  localparam int LEVEL_W     = 3;
  localparam int SOURCE_W    = 6;
  localparam int GROUP_W     = 16;
  localparam int ADDR_W      = 8;
  localparam int GROUP_IDX_W = 4;

  // Level field positions, field 0 is the upper field
  localparam int UPPER_FIELD_LSB  = 12;
  localparam int SECOND_FIELD_LSB = 8;
  localparam int THIRD_FIELD_LSB  = 4;
  localparam int LOWER_FIELD_LSB  = 0;

  localparam logic [15:0] LEVEL_RESET      = 16'h7777;
  localparam logic [15:0] LEVEL_WRITE_MASK = 16'h7777;
  localparam logic [31:0] ENABLE_RESET     = 32'h0000_0000;

  // Byte addresses
  localparam logic [7:0] GROUP_BASE   = 8'h00;
  localparam logic [7:0] GROUP_LAST   = 8'h30;
  localparam logic [7:0] ENABLE_LO    = 8'h34;
  localparam logic [7:0] ENABLE_HI    = 8'h38;
  localparam logic [7:0] PENDING_LO   = 8'h3C;
  localparam logic [7:0] PENDING_HI   = 8'h40;
  localparam logic [7:0] STATUS       = 8'h44;
  localparam int         ENABLE_HI_W  = NUM_SOURCES - 32;

  // Status register layout
  localparam int STAT_VALID_BIT  = 0;
  localparam int STAT_LEVEL_LSB  = 4;
  localparam int STAT_SOURCE_LSB = 8;
  localparam int STAT_NMI_BIT    = 16;

  typedef enum logic [2:0] {
    TGT_GROUP,
    TGT_ENABLE_LO,
    TGT_ENABLE_HI,
    TGT_PENDING_LO,
    TGT_PENDING_HI,
    TGT_STATUS,
    TGT_NONE
  } target_t;

endpackage

// ==== hw/irq_level_addr_decode.sv ====
// Address decoder for the interrupt level register map.
// Assumes word aligned APB addresses; any other address is unmapped.
`timescale 1ns/1ps

module irq_level_addr_decode (
  input  wire logic [irq_level_pkg::ADDR_W-1:0]      paddr,
  output irq_level_pkg::target_t                     target,
  output logic      [irq_level_pkg::GROUP_IDX_W-1:0] groupIndex
);

  always_comb begin
    groupIndex = paddr[irq_level_pkg::GROUP_IDX_W+1:2];
    if (paddr[1:0] != 2'h0) begin
      target = irq_level_pkg::TGT_NONE;
    end else if (paddr <= irq_level_pkg::GROUP_LAST) begin
      target = irq_level_pkg::TGT_GROUP;
    end else begin
      case (paddr)
        irq_level_pkg::ENABLE_LO:  target = irq_level_pkg::TGT_ENABLE_LO;
        irq_level_pkg::ENABLE_HI:  target = irq_level_pkg::TGT_ENABLE_HI;
        irq_level_pkg::PENDING_LO: target = irq_level_pkg::TGT_PENDING_LO;
        irq_level_pkg::PENDING_HI: target = irq_level_pkg::TGT_PENDING_HI;
        irq_level_pkg::STATUS:     target = irq_level_pkg::TGT_STATUS;
        default:                   target = irq_level_pkg::TGT_NONE;
      endcase
    end
  end

endmodule

// ==== hw/irq_level_arbiter.sv ====
// Picks the highest level among pending, enabled maskable sources.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps

module irq_level_arbiter #(
  parameter int N = irq_level_pkg::NUM_SOURCES
) (
  input  wire logic [N-1:0]                         request,
  input  wire logic [N*irq_level_pkg::LEVEL_W-1:0]  levels,
  output logic                                      found,
  output logic      [irq_level_pkg::SOURCE_W-1:0]   winner,
  output logic      [irq_level_pkg::LEVEL_W-1:0]    winLevel
);

  always_comb begin
    logic [irq_level_pkg::LEVEL_W-1:0] lvl;
    lvl      = '0;
    found    = 1'b0;
    winner   = '0;
    winLevel = '0;
    for (int i = 0; i < N; i++) begin
      lvl = levels[i*irq_level_pkg::LEVEL_W +: irq_level_pkg::LEVEL_W];
      // Unsigned compare; strict greater keeps the lower index on a tie
      if (request[i] && (!found || lvl > winLevel)) begin // [RULE_02] [RULE_06]
        found    = 1'b1;
        winner   = irq_level_pkg::SOURCE_W'(i);
        winLevel = lvl;
      end
    end
  end

endmodule

// ==== hw/irq_level_regs.sv ====
// Interrupt level register bank with APB slave and request arbitration.
// Assumes source requests and the NMI request are levels from logic on clk.
`timescale 1ns/1ps

// What this block does
// RULE_01 - Each group register holds four writable 3-bit levels at 14:12, 10:8, 6:4, 2:0.
// RULE_02 - A level is unsigned: 000 is lowest, 111 highest, binary order between.
// RULE_03 - Bits 15, 11, 7 and 3 read zero and ignore writes.
// RULE_04 - Levels govern only maskable sources; NMI bypasses them.
// RULE_05 - Writing one byte lane changes both fields in that byte and leaves the other two fields unchanged.
// RULE_06 - Highest enabled pending level is forwarded; ties go to the lower source index.
module irq_level_regs (
  input  wire logic                                    clk,
  input  wire logic                                    rst,
  input  wire logic                                    psel,
  input  wire logic                                    penable,
  input  wire logic                                    pwrite,
  input  wire logic [irq_level_pkg::ADDR_W-1:0]        paddr,
  input  wire logic [31:0]                             pwdata,
  input  wire logic [3:0]                              pstrb,
  output logic      [31:0]                             prdata,
  output logic                                         pready,
  output logic                                         pslverr,
  input  wire logic [irq_level_pkg::NUM_SOURCES-1:0]   sourceReq,
  input  wire logic                                    nmiReq,
  output logic                                         cpuIrqValid,
  output logic      [irq_level_pkg::SOURCE_W-1:0]      cpuIrqSource,
  output logic      [irq_level_pkg::LEVEL_W-1:0]       cpuIrqLevel,
  output logic                                         cpuNmi
);

  localparam int NG = irq_level_pkg::NUM_GROUPS;
  localparam int NS = irq_level_pkg::NUM_SOURCES;
  localparam int LW = irq_level_pkg::LEVEL_W;
  localparam int EW = irq_level_pkg::ENABLE_HI_W;

  typedef struct packed {
    logic [NG-1:0][15:0]                  level;
    logic [NS-1:0]                        enable;
    logic                                 pready;
    logic                                 pslverr;
    logic [31:0]                          prdata;
    logic                                 irqValid;
    logic [irq_level_pkg::SOURCE_W-1:0]   irqSource;
    logic [LW-1:0]                        irqLevel;
    logic                                 nmi;
  } state_t;

  state_t s;
  state_t next_s;

  irq_level_pkg::target_t                 target;
  logic [irq_level_pkg::GROUP_IDX_W-1:0]  groupIndex;
  logic [NS*LW-1:0]                       flatLevels;
  logic [NS-1:0]                          armed;
  logic                                   found;
  logic [irq_level_pkg::SOURCE_W-1:0]     winner;
  logic [LW-1:0]                          winLevel;
  logic                                   setupPhase;
  logic                                   writeNow;
  logic [31:0]                            readValue;

  // Byte enables widened to a bit mask
  function automatic logic [31:0] byteMask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

  // Level field of a source; field 0 of a group is the upper field
  function automatic logic [LW-1:0] fieldOf(input logic [15:0] grp, input int f);
    logic [LW-1:0] v;
    case (f)
      0:       v = grp[irq_level_pkg::UPPER_FIELD_LSB +: LW];
      1:       v = grp[irq_level_pkg::SECOND_FIELD_LSB +: LW];
      2:       v = grp[irq_level_pkg::THIRD_FIELD_LSB +: LW];
      default: v = grp[irq_level_pkg::LOWER_FIELD_LSB +: LW];
    endcase
    return v;
  endfunction

  irq_level_addr_decode u_decode (
    .paddr      (paddr),
    .target     (target),
    .groupIndex (groupIndex)
  );

  always_comb begin
    flatLevels = '0;
    for (int g = 0; g < NG; g++) begin
      for (int f = 0; f < irq_level_pkg::FIELDS; f++) begin
        flatLevels[(g*irq_level_pkg::FIELDS+f)*LW +: LW] = fieldOf(s.level[g], f); // [RULE_01]
      end
    end
  end

  // Only maskable sources enter arbitration
  assign armed = sourceReq & s.enable; // [RULE_04]

  irq_level_arbiter #(
    .N (NS)
  ) u_arbiter (
    .request  (armed),
    .levels   (flatLevels),
    .found    (found),
    .winner   (winner),
    .winLevel (winLevel)
  );

  assign setupPhase = psel & ~penable;
  assign writeNow   = psel & penable & s.pready & pwrite;

  always_comb begin
    readValue = '0;
    case (target)
      irq_level_pkg::TGT_GROUP: begin
        // Reserved positions are stored as zero and read back as zero
        readValue[15:0] = s.level[groupIndex] & irq_level_pkg::LEVEL_WRITE_MASK; // [RULE_03]
      end
      irq_level_pkg::TGT_ENABLE_LO: begin
        readValue = s.enable[31:0];
      end
      irq_level_pkg::TGT_ENABLE_HI: begin
        readValue[EW-1:0] = s.enable[NS-1:32];
      end
      irq_level_pkg::TGT_PENDING_LO: begin
        readValue = sourceReq[31:0];
      end
      irq_level_pkg::TGT_PENDING_HI: begin
        readValue[EW-1:0] = sourceReq[NS-1:32];
      end
      irq_level_pkg::TGT_STATUS: begin
        readValue[irq_level_pkg::STAT_VALID_BIT] = s.irqValid;
        readValue[irq_level_pkg::STAT_LEVEL_LSB +: LW] = s.irqLevel;
        readValue[irq_level_pkg::STAT_SOURCE_LSB +: irq_level_pkg::SOURCE_W] = s.irqSource;
        readValue[irq_level_pkg::STAT_NMI_BIT] = s.nmi;
      end
      default: begin
        readValue = '0;
      end
    endcase
  end

  always_comb begin
    logic [31:0] m;
    logic [15:0] lm;
    logic [31:0] en;
    m      = byteMask(pstrb);
    lm     = m[15:0] & irq_level_pkg::LEVEL_WRITE_MASK;
    en     = '0;
    next_s = s;

    // No wait state: ready in the first access cycle
    next_s.pready = setupPhase;
    if (setupPhase) begin
      next_s.pslverr = (target == irq_level_pkg::TGT_NONE);
      next_s.prdata  = (target == irq_level_pkg::TGT_NONE) ? 32'h0000_0000 : readValue;
    end else begin
      // Read data and error stand only in the access cycle that carries ready
      next_s.pslverr = 1'b0;
      next_s.prdata  = 32'h0000_0000;
    end

    if (writeNow) begin
      case (target)
        irq_level_pkg::TGT_GROUP: begin
          // Only strobed, writable bits change; other fields keep their values
          next_s.level[groupIndex] = (s.level[groupIndex] & ~lm) | (pwdata[15:0] & lm); // [RULE_03] [RULE_05]
        end
        irq_level_pkg::TGT_ENABLE_LO: begin
          next_s.enable[31:0] = (s.enable[31:0] & ~m) | (pwdata & m);
        end
        irq_level_pkg::TGT_ENABLE_HI: begin
          en = {{(32-EW){1'b0}}, s.enable[NS-1:32]};
          en = (en & ~m) | (pwdata & m);
          next_s.enable[NS-1:32] = en[EW-1:0];
        end
        default: begin
          next_s.enable = s.enable;
        end
      endcase
    end

    next_s.irqValid  = found; // [RULE_06]
    next_s.irqSource = found ? winner : '0;
    next_s.irqLevel  = found ? winLevel : '0;
    // NMI is registered for one cycle, untouched by any level field
    next_s.nmi       = nmiReq; // [RULE_04]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.level <= {NG{irq_level_pkg::LEVEL_RESET}};
      s.enable <= {irq_level_pkg::ENABLE_RESET[EW-1:0], irq_level_pkg::ENABLE_RESET};
    end else begin
      s <= next_s;
    end
  end

  assign prdata       = s.prdata;
  assign pready       = s.pready;
  assign pslverr      = s.pslverr;
  assign cpuIrqValid  = s.irqValid;
  assign cpuIrqSource = s.irqSource;
  assign cpuIrqLevel  = s.irqLevel;
  assign cpuNmi       = s.nmi;

endmodule

// ==== sim/irq_level_regs_properties.sv ====
// Port-level checks for the interrupt level register block.
// Assumes all ports on clk with synchronous active high rst.
`timescale 1ns/1ps
module irq_level_regs_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [51:0] sourceReq,
  input wire logic        nmiReq,
  input wire logic        cpuIrqValid,
  input wire logic [5:0]  cpuIrqSource,
  input wire logic [2:0]  cpuIrqLevel,
  input wire logic        cpuNmi
);
  logic [51:0] prevReq;
  always_ff @(posedge clk) prevReq <= sourceReq;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  apb_ready_after_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  read_quiet_a: assert property (!pready |-> prdata == 32'h0 && !pslverr) else $error("data or error without ready");
  unmapped_error_a: assert property (psel && pready && paddr > 8'h44 |-> pslverr) else $error("no error");
  reserved_zero_a: assert property (psel && pready && !pwrite && paddr <= 8'h30 |-> (prdata & 32'hFFFF_8888) == 32'h0)
    else $error("reserved bits set");
  nmi_follow_a: assert property (1'b1 |=> cpuNmi == $past(nmiReq)) else $error("nmi not one cycle later");
  winner_pending_a: assert property (cpuIrqValid |-> prevReq[cpuIrqSource]) else $error("winner not pending");
  idle_no_irq_a: assert property (prevReq == 52'h0 |-> !cpuIrqValid) else $error("irq without request");
  idle_zero_a: assert property (!cpuIrqValid |-> cpuIrqSource == 6'h0 && cpuIrqLevel == 3'h0)
    else $error("idle outputs not zero");
  cov_write: cover property (psel && pready && pwrite);
  cov_irq: cover property (cpuIrqValid && cpuIrqLevel == 3'h7);
  cov_nmi: cover property (cpuNmi);
endmodule

bind irq_level_regs irq_level_regs_checker u_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .sourceReq, .nmiReq, .cpuIrqValid, .cpuIrqSource, .cpuIrqLevel, .cpuNmi);

// ==== sim/cpu_core_model.sv ====
// Behavioural CPU core that takes forwarded interrupt requests.
// Assumes requests arrive registered on clk from the level block.
`timescale 1ns/1ps
module cpu_core_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       irqValid,
  input  wire logic [2:0] irqLevel,
  input  wire logic       nmi,
  output logic      [3:0] takenCnt
);
  // Level 0 stays masked by the core; NMI is taken whatever the levels
  always_ff @(posedge clk) begin
    if (rst) takenCnt <= 4'h0;
    else if ((irqValid && irqLevel != 3'h0) || nmi) takenCnt <= takenCnt + 4'h1;
  end
endmodule

// ==== sim/irq_level_regs_tb.sv ====
// Self-checking bench for the interrupt level register block.
// Assumes the design and the core model compiled before it.
`timescale 1ns/1ps
module irq_level_regs_tb;
  logic        clk, rst, psel, penable, pwrite, nmiReq, pready, pslverr, cpuIrqValid, cpuNmi, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, d, p;
  logic [3:0]  pstrb, s, cpuTaken;
  logic [51:0] sourceReq, en, q;
  logic [5:0]  cpuIrqSource;
  logic [2:0]  cpuIrqLevel;
  logic [15:0] lv[13];
  int          errorCnt, numChecks, g;
  int          seed = 71822;

  irq_level_regs DUT (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .sourceReq, .nmiReq, .cpuIrqValid, .cpuIrqSource, .cpuIrqLevel, .cpuNmi);
  cpu_core_model core (.clk, .rst, .irqValid(cpuIrqValid), .irqLevel(cpuIrqLevel), .nmi(cpuNmi), .takenCnt(cpuTaken));

  always #2.5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkOut(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: forwarded %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] st);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd; pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) chk(32'h0, 32'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Expected {valid, source, level}: highest level wins, lowest index on a tie
  function automatic logic [31:0] pick(input logic [51:0] m);
    logic [9:0] b;
    logic [2:0] l;
    b = 10'h0;
    for (int k = 0; k < 52; k++) begin
      l = 3'(lv[k/4] >> (12 - 4 * (k % 4)));
      if (m[k] && (!b[9] || l > b[2:0])) b = {1'b1, 6'(k), l};
    end
    return {22'h0, b};
  endfunction

  task automatic final_report();
    $display("checks %0d errors %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #50000;
    errorCnt++;
    final_report();
  end

  initial begin
    clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0; pstrb = 4'h0;
    sourceReq = 52'h0; nmiReq = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 13; i++) begin
      lv[i] = 16'h7777;
      apb(1'b0, 8'(i * 4), 32'h0, 4'h0);
      chk(r, 32'h7777);
    end
    for (int i = 0; i < 40; i++) begin
      g = {$random(seed)} % 13;
      d = $random(seed);
      s = (i < 13) ? 4'hF : 4'($random(seed));
      apb(1'b1, 8'(g * 4), d, s);
      if (s[0]) lv[g][7:0] = d[7:0] & 8'h77;
      if (s[1]) lv[g][15:8] = d[15:8] & 8'h77;
      apb(1'b0, 8'(g * 4), 32'h0, 4'h0);
      chk(r, {16'h0, lv[g]});
    end
    apb(1'b1, 8'h80, 32'hFFFF_FFFF, 4'hF);
    chk({r[30:0], e}, 32'h1);
    for (int i = 0; i < 30; i++) begin
      if (i % 10 == 0) begin
        en = (i == 0) ? {52{1'b1}} : 52'({$random(seed), $random(seed)});
        apb(1'b1, 8'h34, en[31:0], 4'hF);
        apb(1'b1, 8'h38, {12'h0, en[51:32]}, 4'hF);
        apb(1'b0, 8'h38, 32'h0, 4'h0);
        chk(r, {12'h0, en[51:32]});
      end
      q = (i < 2) ? {52{i == 0}} : 52'({$random(seed), $random(seed)});
      sourceReq <= q;
      repeat (2) @(posedge clk);
      p = pick(q & en);
      chkOut({22'h0, cpuIrqValid, cpuIrqSource, cpuIrqLevel}, p);
      // Status holds registered copies of the forwarded outputs
      apb(1'b0, 8'h44, 32'h0, 4'h0);
      chk(r, {18'h0, p[8:3], 1'b0, p[2:0], 3'h0, p[9]});
      apb(1'b0, 8'h3C, 32'h0, 4'h0);
      chk(r, q[31:0]);
      apb(1'b0, 8'h40, 32'h0, 4'h0);
      chk(r, {12'h0, q[51:32]});
    end
    // Reset in mid-run restores all levels to 7 and clears the enables
    sourceReq <= 52'h0;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    chkOut({26'h0, cpuTaken, cpuIrqValid, cpuNmi}, 32'h0);
    rst <= 1'b0;
    for (int i = 0; i < 13; i += 4) begin
      apb(1'b0, 8'(i * 4), 32'h0, 4'h0);
      chk(r, 32'h7777);
    end
    apb(1'b0, 8'h34, 32'h0, 4'h0);
    chk(r, 32'h0);
    // All sources pending but disabled; only NMI reaches the core, for two cycles
    sourceReq <= {52{1'b1}};
    nmiReq <= 1'b1;
    repeat (2) @(posedge clk);
    chkOut({31'h0, cpuNmi}, 32'h1);
    nmiReq <= 1'b0;
    repeat (2) @(posedge clk);
    chkOut({26'h0, cpuTaken, cpuIrqValid, cpuNmi}, 32'h8);
    final_report();
  end
endmodule
